// >>> rtl/cdc_ctrl.sv
// Purpose: unified copy-back cache plus page-mode dram controller
// Assumes: cpu holds i_cpu_req until o_cpu_rdy; inputs synchronous
// Notes:   unshadowed rom and unmapped space go out on the rom port
// Functional notes
// RULE1 - write hit updates only the cached copy, no memory write
// RULE2 - write hit completes in one bus cycle, no memory wait
// RULE3 - dirty data written back only when its line is replaced
// RULE4 - one unified 8KB cache over the lowest 16MB
// RULE5 - two programmable non-cacheable areas bypass the cache
// RULE6 - accesses inside the open dram page need no wait states
// RULE7 - hidden refresh never stalls the cpu; the code serves hits during a refresh started from idle, but a miss waits for it
// RULE8 - hidden refresh waits while main memory is busy, runs when idle
// RULE9 - two banks of four modules, 256K, 1M or 4M, up to 32MB
// RULE10 - shadowed bios regions are served from dram, not rom
// RULE11 - cache is two-way set associative, copy-back in both ways
// RULE12 - dram wait states are programmable
// RULE13 - write miss goes to memory without allocating a line
// RULE14 - deferred refresh is forced after a bounded delay
`timescale 1ns/100ps
module cdc_ctrl
   import cdc_pkg::*;
(
   input  wire logic        i_core_clk,  // core clock
   input  wire logic        i_nrst,      // sync reset, low
   input  wire logic        i_cpu_req,   // held till rdy
   input  wire logic        i_cpu_we,    // write access
   input  wire logic [29:0] i_cpu_addr,  // word address
   input  wire logic [3:0]  i_cpu_be,    // byte enables
   input  wire logic [31:0] i_cpu_wdata, // write data
   output logic             o_cpu_rdy,   // done pulse
   output logic [31:0]      o_cpu_rdata, // read data
   output logic [1:0]       o_ras_n,     // row strobe per bank
   output logic [3:0]       o_cas_n,     // column strobe per lane
   output logic             o_we_n,      // dram write
   output logic [10:0]      o_ma,        // muxed address
   output logic [31:0]      o_md_out,    // dram/rom write data
   output logic             o_md_oe,     // dram data drive
   input  wire logic [31:0] i_md_in,     // dram read data
   output logic             o_rom_req,   // level till ack
   output logic             o_rom_we,    // rom port write
   output logic [29:0]      o_rom_addr,  // rom port address
   input  wire logic        i_rom_ack,   // rom port done
   input  wire logic [31:0] i_rom_rdata, // rom port data
   input  wire logic [3:0]  i_reg_addr,  // register offset
   input  wire logic        i_reg_wr,    // register write
   input  wire logic        i_reg_rd,    // register read
   input  wire logic [31:0] i_reg_wdata, // register data in
   output logic [31:0]      o_reg_rdata  // data after read
);
   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      cdc_state_t  st;
      logic [4:0]  cnt;
      logic        busy;
      logic        we;
      logic [29:0] addr;
      logic [3:0]  dbe;
      logic        dwe;
      logic [29:0] da;
      logic [31:0] dout;
      logic        fill;
      logic        wb;
      logic        ext;
      logic        vway;
      logic        pg;
      logic        opn;
      logic        opn_bank;
      logic [10:0] opn_row;
      logic [10:0] ref_tmr;
      logic [2:0]  ref_pend;
      logic [1:0]  ras_n;
      logic [3:0]  cas_n;
      logic        we_n;
      logic [10:0] ma;
      logic        oe;
      logic        rdy;
      logic [31:0] rdata;
      logic        rom_req;
      logic [11:0] ctrl;
      logic [16:0] nc0;
      logic [16:0] nc1;
      logic [31:0] regrd;
   } cdc_st_t;

   cdc_st_t     s_ff;
   cdc_st_t     nxt_s;
   logic [1:0]  hitw;
   logic [31:0] way_dat [2];
   logic [11:0] way_tag [2];
   logic [1:0]  way_vld;
   logic [1:0]  way_dty;
   logic [1:0]  c_we;
   logic [9:0]  c_idx;
   logic [11:0] c_tag;
   logic [31:0] c_dat;
   logic        c_dty;
   logic        lru_we;
   logic        lru_val;
   logic [1023:0] lru_ff;
   logic [22:0] bk0_w;
   logic [22:0] bk1_w;
   logic        in_nc;
   logic        unsh;
   logic        in_mem;
   logic        cab;
   logic        take;
   logic        take_hit;
   logic        take_miss;
   logic        op_bank;
   logic [21:0] op_rel;
   logic [10:0] op_row;
   logic [10:0] op_col;
   logic        pg_hit;
   logic        need_ref;
   logic        ref_inc;
   logic        ref_dec;

   function automatic logic [22:0] bank_words(input logic [1:0] sz);
      unique case (sz)
         2'd1: bank_words = BK_W1;
         2'd2: bank_words = BK_W2;
         2'd3: bank_words = BK_W3;
         default: bank_words = 23'h0;
      endcase
   endfunction

   function automatic logic in_area(input logic [16:0] r,
                                    input logic [7:0]  blk);
      logic [7:0] off;
      off     = blk - r[7:0];
      in_area = r[NC_EN] && (off < r[15:8]);
   endfunction

   // ************************************************
   // cache ways: one tag, data, valid and dirty store each
   // ************************************************
   generate
      for (genvar w = 0; w < 2; w++) begin : g_way
         logic [31:0]   dat_m [1024];
         logic [11:0]   tag_m [1024];
         logic [1023:0] dty_m;
         logic [1023:0] vld_ff;
         always_ff @(posedge i_core_clk) begin
            if (!i_nrst) begin
               vld_ff <= '0;
            end else if (c_we[w]) begin
               vld_ff[c_idx] <= 1'b1;
            end
         end
         // storage needs no reset: valid bits guard it
         always_ff @(posedge i_core_clk) begin
            if (c_we[w]) begin
               dat_m[c_idx] <= c_dat;
               tag_m[c_idx] <= c_tag;
               dty_m[c_idx] <= c_dty;
            end
         end
         assign way_dat[w] = dat_m[i_cpu_addr[9:0]];
         assign way_tag[w] = tag_m[i_cpu_addr[9:0]];
         assign way_vld[w] = vld_ff[i_cpu_addr[9:0]];
         assign way_dty[w] = dty_m[i_cpu_addr[9:0]];
         assign hitw[w]    = way_vld[w] && (way_tag[w] == i_cpu_addr[21:10]); // RULE11
      end
   endgenerate

   // lru bit names the way to replace next
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         lru_ff <= '0;
      end else if (lru_we) begin
         lru_ff[c_idx] <= lru_val;
      end
   end

   // ************************************************
   // address decode
   // ************************************************
   assign bk0_w  = bank_words(s_ff.ctrl[CT_BK0 +: 2]);
   assign bk1_w  = bank_words(s_ff.ctrl[CT_BK1 +: 2]);
   assign in_nc  = in_area(s_ff.nc0, i_cpu_addr[21:14])
                || in_area(s_ff.nc1, i_cpu_addr[21:14]); // RULE5
   assign unsh   = ((i_cpu_addr[29:14] == SYS_ROM) && !s_ff.ctrl[CT_SHSYS])
                || ((i_cpu_addr[29:13] == VID_ROM) && !s_ff.ctrl[CT_SHVID]); // RULE10
   assign in_mem = (i_cpu_addr[29:23] == 7'h00)
                && ({1'b0, i_cpu_addr[22:0]} < (24'(bk0_w) + 24'(bk1_w))); // RULE9
   assign cab    = s_ff.ctrl[CT_CACHE] && (i_cpu_addr[29:22] == 8'h00)
                && !in_nc && !unsh && in_mem; // RULE4
   // a request is ignored while rdy shows, the cpu still holds it then
   assign take      = i_cpu_req && !s_ff.rdy && !s_ff.busy;
   assign take_hit  = take && cab && (|hitw);
   assign take_miss = take && !(cab && (|hitw));

   // bank and row/column split of the current dram word
   assign op_bank = (s_ff.da[22:0] >= bk0_w); // RULE9
   assign op_rel  = op_bank ? 22'(s_ff.da[22:0] - bk0_w) : s_ff.da[21:0];
   always_comb begin
      unique case (s_ff.ctrl[(op_bank ? CT_BK1 : CT_BK0) +: 2])
         2'd1: begin
            op_row = {2'b00, op_rel[17:9]};
            op_col = {2'b00, op_rel[8:0]};
         end
         2'd2: begin
            op_row = {1'b0, op_rel[19:10]};
            op_col = {1'b0, op_rel[9:0]};
         end
         default: begin
            op_row = op_rel[21:11];
            op_col = op_rel[10:0];
         end
      endcase
   end
   assign pg_hit   = s_ff.opn && (s_ff.opn_bank == op_bank)
                  && (s_ff.opn_row == op_row); // RULE6
   assign need_ref = (s_ff.ref_pend != 3'h0)
                  && (!s_ff.ctrl[CT_HIDE] || (s_ff.ref_pend >= REF_FORCE)); // RULE8 RULE14
   assign ref_inc  = (s_ff.ref_tmr == 11'h0);

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      nxt_s   = s_ff;
      nxt_s.rdy   = 1'b0;
      nxt_s.regrd = 32'h0;
      c_we    = 2'b00;
      c_idx   = i_cpu_addr[9:0];
      c_tag   = i_cpu_addr[21:10];
      c_dat   = i_cpu_wdata;
      c_dty   = 1'b0;
      lru_we  = 1'b0;
      lru_val = 1'b0;
      ref_dec = 1'b0;
      nxt_s.ref_tmr = ref_inc ? 11'(REF_CYC - 1) : s_ff.ref_tmr - 11'h1;
      // hits are served beside a refresh started from idle, not while a miss is busy
      if (take_hit) begin
         nxt_s.rdy   = 1'b1; // RULE2 RULE7
         nxt_s.rdata = way_dat[hitw[1]];
         lru_we  = 1'b1;
         lru_val = !hitw[1];
         if (i_cpu_we) begin
            c_we  = hitw; // RULE1
            c_dty = 1'b1;
            for (int b = 0; b < 4; b++) begin
               c_dat[8*b +: 8] = i_cpu_be[b] ? i_cpu_wdata[8*b +: 8]
                                             : way_dat[hitw[1]][8*b +: 8];
            end
         end
      end
      // latch a miss; dirty victim goes out first
      if (take_miss) begin
         nxt_s.busy = 1'b1;
         nxt_s.we   = i_cpu_we;
         nxt_s.addr = i_cpu_addr;
         nxt_s.ext  = unsh || !in_mem; // RULE10
         nxt_s.fill = cab && !i_cpu_we; // RULE13
         nxt_s.vway = !way_vld[0] ? 1'b0 : (!way_vld[1] ? 1'b1 : lru_ff[i_cpu_addr[9:0]]);
         nxt_s.wb   = cab && !i_cpu_we && way_vld[nxt_s.vway] && way_dty[nxt_s.vway]; // RULE3
         nxt_s.da   = nxt_s.wb ? {8'h00, way_tag[nxt_s.vway], i_cpu_addr[9:0]}
                               : i_cpu_addr;
         nxt_s.dout = nxt_s.wb ? way_dat[nxt_s.vway] : i_cpu_wdata;
         nxt_s.dwe  = nxt_s.wb || i_cpu_we;
         nxt_s.dbe  = i_cpu_we ? i_cpu_be : 4'hF;
      end
      unique case (s_ff.st)
         S_IDLE: begin
            if (take_miss) begin
               nxt_s.st = nxt_s.ext ? S_EXT : S_PREP;
               nxt_s.rom_req = nxt_s.ext;
            end else if (s_ff.ref_pend != 3'h0) begin
               nxt_s.st = S_REF; // RULE8
            end
         end
         S_PREP: begin
            if (need_ref) begin
               nxt_s.st = S_REF; // RULE14
            end else if (pg_hit) begin
               nxt_s.st    = S_CAS;
               nxt_s.pg    = 1'b1;
               nxt_s.cnt   = 5'h0; // RULE6
               nxt_s.ma    = op_col;
               nxt_s.cas_n = ~s_ff.dbe;
               nxt_s.we_n  = !s_ff.dwe;
               nxt_s.oe    = s_ff.dwe;
            end else begin
               nxt_s.st    = S_PRE;
               nxt_s.pg    = 1'b0;
               nxt_s.ras_n = 2'b11;
               nxt_s.opn   = 1'b0;
               nxt_s.cnt   = 5'(TRP_CYC - 1);
            end
         end
         S_PRE: begin
            nxt_s.cnt = s_ff.cnt - 5'h1;
            if (s_ff.cnt == 5'h0) begin
               nxt_s.st  = S_RAS;
               nxt_s.cnt = 5'(TRCD_CYC - 1);
               nxt_s.ma  = op_row;
               nxt_s.ras_n[op_bank] = 1'b0; // RULE9
               nxt_s.opn      = 1'b1;
               nxt_s.opn_bank = op_bank;
               nxt_s.opn_row  = op_row;
            end
         end
         S_RAS: begin
            nxt_s.cnt = s_ff.cnt - 5'h1;
            if (s_ff.cnt == 5'h0) begin
               nxt_s.st    = S_CAS;
               nxt_s.cnt   = {3'b000, s_ff.ctrl[CT_WS +: 2]}; // RULE12
               nxt_s.ma    = op_col;
               nxt_s.cas_n = ~s_ff.dbe;
               nxt_s.we_n  = !s_ff.dwe;
               nxt_s.oe    = s_ff.dwe;
            end
         end
         S_CAS: begin
            nxt_s.cnt = s_ff.cnt - 5'h1;
            if (s_ff.cnt == 5'h0) begin
               nxt_s.cas_n = 4'hF;
               nxt_s.we_n  = 1'b1;
               nxt_s.oe    = 1'b0;
               nxt_s.st    = S_IDLE;
               if (s_ff.wb) begin
                  // victim is out, now fetch the missed word
                  nxt_s.wb  = 1'b0;
                  nxt_s.da  = s_ff.addr;
                  nxt_s.dwe = 1'b0;
                  nxt_s.dbe = 4'hF;
                  nxt_s.st  = S_PREP;
               end else begin
                  nxt_s.busy  = 1'b0;
                  nxt_s.rdy   = 1'b1;
                  nxt_s.rdata = s_ff.we ? s_ff.rdata : i_md_in;
                  if (s_ff.fill) begin
                     c_we[s_ff.vway] = 1'b1;
                     c_idx   = s_ff.addr[9:0];
                     c_tag   = s_ff.addr[21:10];
                     c_dat   = i_md_in;
                     lru_we  = 1'b1;
                     lru_val = !s_ff.vway;
                  end
               end
            end
         end
         S_REF: begin
            // cas before ras: precharge, then ras low for the pulse
            nxt_s.cnt = s_ff.cnt - 5'h1;
            if (s_ff.cnt == 5'(TRAS_CYC)) begin
               nxt_s.ras_n = 2'b00;
            end
            if (s_ff.cnt == 5'h0) begin
               nxt_s.ras_n = 2'b11;
               nxt_s.cas_n = 4'hF;
               ref_dec = 1'b1;
               nxt_s.st = S_IDLE;
               if (nxt_s.busy) begin
                  nxt_s.st = nxt_s.ext ? S_EXT : S_PREP;
                  nxt_s.rom_req = nxt_s.ext;
               end
            end
         end
         S_EXT: begin
            if (i_rom_ack) begin
               nxt_s.rom_req = 1'b0;
               nxt_s.busy    = 1'b0;
               nxt_s.rdy     = 1'b1;
               nxt_s.rdata   = s_ff.we ? s_ff.rdata : i_rom_rdata;
               nxt_s.st      = S_IDLE;
            end
         end
      endcase
      // entry into refresh sets up its strobes and length
      if (nxt_s.st == S_REF && s_ff.st != S_REF) begin
         nxt_s.cnt   = 5'(TRP_CYC + TRAS_CYC - 1);
         nxt_s.ras_n = 2'b11;
         nxt_s.cas_n = 4'h0;
         nxt_s.we_n  = 1'b1;
         nxt_s.oe    = 1'b0;
         nxt_s.opn   = 1'b0;
      end
      // pending count saturates, so a lost timer tick only shortens margin
      if (ref_inc && !ref_dec && s_ff.ref_pend != 3'h7) begin
         nxt_s.ref_pend = s_ff.ref_pend + 3'h1;
      end else if (ref_dec && !ref_inc) begin
         nxt_s.ref_pend = s_ff.ref_pend - 3'h1;
      end
      // register port
      if (i_reg_wr) begin
         unique case (i_reg_addr)
            REG_CTRL: nxt_s.ctrl = i_reg_wdata[11:0];
            REG_NC0:  nxt_s.nc0  = i_reg_wdata[16:0];
            REG_NC1:  nxt_s.nc1  = i_reg_wdata[16:0];
            default:  nxt_s.ctrl = s_ff.ctrl;
         endcase
      end
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            REG_CTRL: nxt_s.regrd = {20'h0, s_ff.ctrl};
            REG_NC0:  nxt_s.regrd = {15'h0, s_ff.nc0};
            REG_NC1:  nxt_s.regrd = {15'h0, s_ff.nc1};
            REG_STAT: nxt_s.regrd = {19'h0, s_ff.ref_pend, s_ff.st,
                                     s_ff.busy, s_ff.opn, s_ff.pg};
            default:  nxt_s.regrd = 32'h0;
         endcase
      end
   end

   // state register
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         s_ff       <= '0;
         s_ff.st    <= S_IDLE;
         s_ff.ras_n <= 2'b11;
         s_ff.cas_n <= 4'hF;
         s_ff.we_n  <= 1'b1;
         s_ff.ref_tmr <= 11'(REF_CYC - 1);
         s_ff.dbe   <= 4'hF;
         s_ff.ctrl  <= CTRL_RST;
         s_ff.nc0   <= NC_RST;
         s_ff.nc1   <= NC_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // outputs straight from the state register
   assign o_cpu_rdy   = s_ff.rdy;
   assign o_cpu_rdata = s_ff.rdata;
   assign o_ras_n     = s_ff.ras_n;
   assign o_cas_n     = s_ff.cas_n;
   assign o_we_n      = s_ff.we_n;
   assign o_ma        = s_ff.ma;
   assign o_md_out    = s_ff.dout;
   assign o_md_oe     = s_ff.oe;
   assign o_rom_req   = s_ff.rom_req;
   assign o_rom_we    = s_ff.we;
   assign o_rom_addr  = s_ff.addr;
   assign o_reg_rdata = s_ff.regrd;

   // ************************************************
   // checks
   // ************************************************
   logic [4:0] cas_len_ff;
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst || s_ff.st != S_CAS) begin
         cas_len_ff <= 5'h0;
      end else begin
         cas_len_ff <= cas_len_ff + 5'h1;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   a_hit_no_mem: assert property (take_hit && i_cpu_we |=> !s_ff.busy && !s_ff.rom_req) // RULE1
      else $error("write hit went to memory");
   a_hit_one_cyc: assert property (take_hit |=> o_cpu_rdy) // RULE2
      else $error("hit took more than one cycle");
   a_nc_bypass: assert property (take && in_nc |=> !o_cpu_rdy && !s_ff.fill) // RULE5
      else $error("uncached access used the cache");
   a_page_fast: assert property (s_ff.st == S_PREP && pg_hit && !need_ref // RULE6
      |=> s_ff.st == S_CAS) else $error("page hit waited");
   a_ref_defer: assert property (s_ff.st == S_PREP && s_ff.ctrl[CT_HIDE] // RULE8
      && s_ff.ref_pend < REF_FORCE |=> s_ff.st != S_REF) else $error("refresh not deferred");
   a_cas_wait: assert property (s_ff.st == S_CAS && !s_ff.pg && s_ff.cnt == 5'h0 // RULE12
      |-> cas_len_ff == {3'b000, s_ff.ctrl[CT_WS +: 2]}) else $error("cas length wrong");
   c_write_hit: cover property (take_hit && i_cpu_we);
   c_write_back: cover property (s_ff.wb && s_ff.st == S_CAS);
   c_page_hit: cover property (s_ff.st == S_PREP && pg_hit);
endmodule

// >>> common/cdc_pkg.sv
// Purpose: constants and types of the cache and dram controller
// Assumes: 125 MHz core clock, 32-bit word-addressed cpu side
// Notes:   one word per cache line, two ways of 1024 sets
package cdc_pkg;
   // ************************************************
   // clock and dram timing
   // ************************************************
   localparam int unsigned CLK_MHZ  = 125;
   localparam int unsigned TRP_NS   = 60;    // ras precharge, least
   localparam int unsigned TRCD_NS  = 20;    // ras to cas, least
   localparam int unsigned TRAS_NS  = 80;    // refresh ras low, least
   localparam int unsigned REF_NS   = 15600; // refresh interval, longest
   localparam int unsigned TRP_CYC  = (TRP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned TRCD_CYC = (TRCD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned TRAS_CYC = (TRAS_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned REF_CYC  = REF_NS * CLK_MHZ / 1000;
   localparam logic [2:0]  REF_FORCE = 3'h4; // pending count that forces a refresh
   // ************************************************
   // register map and fields
   // ************************************************
   localparam logic [3:0]  REG_CTRL = 4'h0;
   localparam logic [3:0]  REG_NC0  = 4'h4;
   localparam logic [3:0]  REG_NC1  = 4'h8;
   localparam logic [3:0]  REG_STAT = 4'hC;
   localparam int unsigned CT_CACHE = 0;
   localparam int unsigned CT_HIDE  = 1;
   localparam int unsigned CT_SHSYS = 2;
   localparam int unsigned CT_SHVID = 3;
   localparam int unsigned CT_WS    = 4;  // two bits
   localparam int unsigned CT_BK0   = 8;  // two bits
   localparam int unsigned CT_BK1   = 10; // two bits
   localparam int unsigned NC_EN    = 16;
   localparam logic [11:0] CTRL_RST = 12'h002;
   localparam logic [16:0] NC_RST   = 17'h00000;
   // ************************************************
   // address map, word addresses
   // ************************************************
   localparam logic [15:0] SYS_ROM  = 16'h000F; // addr[29:14]
   localparam logic [16:0] VID_ROM  = 17'h00018; // addr[29:13]
   localparam logic [22:0] BK_W1    = 23'h040000; // 256K modules
   localparam logic [22:0] BK_W2    = 23'h100000; // 1M modules
   localparam logic [22:0] BK_W3    = 23'h400000; // 4M modules
   // ************************************************
   // controller states
   // ************************************************
   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_PREP = 7'h02,
      S_PRE  = 7'h04,
      S_RAS  = 7'h08,
      S_CAS  = 7'h10,
      S_REF  = 7'h20,
      S_EXT  = 7'h40
   } cdc_state_t;
endpackage

// >>> bench/cdc_mem_model.sv
// Purpose: dram banks and rom port facing the controller
// Assumes: strobes change just after the core clock edge
// Notes:   released dram data toggles only while cas is high; rom data toggles each cycle except when it answers
`timescale 1ns/100ps
module cdc_mem_model (
   input  wire logic        i_core_clk,  // core clock
   input  wire logic [1:0]  i_ras_n,     // row strobes
   input  wire logic [3:0]  i_cas_n,     // column strobes
   input  wire logic        i_we_n,      // dram write
   input  wire logic [10:0] i_ma,        // muxed address
   input  wire logic [31:0] i_md,        // write data
   input  wire logic        i_rom_req,   // rom request
   input  wire logic [29:0] i_rom_addr,  // rom address
   output logic      [31:0] o_md,        // dram read data
   output logic             o_rom_ack,   // rom done pulse
   output logic      [31:0] o_rom_rdata  // rom data
);
   logic [31:0] mem [int];
   logic [10:0] row_ff;
   logic [1:0]  ras_ff  = 2'h3;
   logic [3:0]  cas_ff  = 4'hF;
   logic        seen_ff = 1'b0;
   int          key, rkey, dly = 0, wr_cnt = 0, rd_cnt = 0, ref_cnt = 0, rom_cnt = 0;
   initial begin
      o_md = 32'h0;
      o_rom_ack = 1'b0;
      o_rom_rdata = 32'h0;
   end
   // dram: ras low without cas, or cas before ras, counts as refresh
   always @(posedge i_core_clk) begin
      ras_ff <= i_ras_n;
      cas_ff <= i_cas_n;
      key = {i_ras_n[0], row_ff, i_ma};
      if ((ras_ff & ~i_ras_n) != 2'h0) begin
         row_ff <= i_ma;
         seen_ff <= (i_cas_n != 4'hF);
         if (i_cas_n != 4'hF)
            ref_cnt++;
      end else if (i_cas_n != 4'hF)
         seen_ff <= 1'b1;
      if ((~ras_ff & i_ras_n) != 2'h0 && !seen_ff)
         ref_cnt++;
      if ((cas_ff & ~i_cas_n) != 4'h0 && i_ras_n != 2'h3) begin
         if (!i_we_n) begin
            mem[key] = i_md;
            wr_cnt++;
         end else begin
            rd_cnt++;
         end
      end
   end
   // data lag cas by half a cycle
   always @(negedge i_core_clk) begin
      rkey = {i_ras_n[0], row_ff, i_ma};
      if (i_cas_n != 4'hF && i_we_n && ^i_ras_n)
         o_md <= mem.exists(rkey) ? mem[rkey] : 32'h0;
      else if (i_cas_n == 4'hF)
         o_md <= ~o_md;
   end
   // rom: slow device, answers three cycles into a request
   always @(posedge i_core_clk) begin
      o_rom_ack <= 1'b0;
      o_rom_rdata <= ~o_rom_rdata;
      if (i_rom_req && !o_rom_ack)
         dly++;
      if (dly == 3) begin
         o_rom_ack <= 1'b1;
         o_rom_rdata <= {2'h0, i_rom_addr};
         dly = 0;
         rom_cnt++;
      end
   end
endmodule

// >>> bench/tb_cache_dram_controller.sv
// Purpose: self-checking bench of the cache and dram controller
// Assumes: cpu holds its request until the ready pulse
// Notes:   a scoreboard memory predicts every checked dram read value
`timescale 1ns/100ps
module tb_cache_dram_controller
   import cdc_pkg::*;
();
   logic        clk = 1'b0, nrst = 1'b0, req = 1'b0, we = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        rdy, we_n, md_oe, rom_req, rom_we, rom_ack;
   logic [1:0]  ras_n;
   logic [3:0]  cas_n, reg_addr = 4'h0;
   logic [10:0] ma;
   logic [29:0] addr = '0, rom_addr, a;
   logic [31:0] wdata = '0, reg_wdata = '0, rdata, md_out, md_in, rom_rdata, reg_rdata, t;
   logic [31:0] sb [logic [29:0]];
   logic [32:0] exp_q [$];
   int          num_errors = 0, comparisons = 0, cyc = 0, seed = 24727, lat, n0;
   always #4 clk = ~clk;
   cdc_ctrl cdc_ctrl_inst (.i_core_clk(clk), .i_nrst(nrst), .i_cpu_req(req), .i_cpu_we(we),
      .i_cpu_addr(addr), .i_cpu_be(4'hF), .i_cpu_wdata(wdata), .o_cpu_rdy(rdy),
      .o_cpu_rdata(rdata), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_ma(ma),
      .o_md_out(md_out), .o_md_oe(md_oe), .i_md_in(md_in), .o_rom_req(rom_req),
      .o_rom_we(rom_we), .o_rom_addr(rom_addr), .i_rom_ack(rom_ack), .i_rom_rdata(rom_rdata),
      .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata),
      .o_reg_rdata(reg_rdata));
   cdc_mem_model mem_inst (.i_core_clk(clk), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
      .i_ma(ma), .i_md(md_out), .i_rom_req(rom_req), .i_rom_addr(rom_addr), .o_md(md_in),
      .o_rom_ack(rom_ack), .o_rom_rdata(rom_rdata));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ************************************************
   // bus tasks
   // ************************************************
   task automatic reg_w(input logic [3:0] ra, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= ra;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_r(input logic [3:0] ra, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= ra;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check("reg", reg_rdata, e);
   endtask
   // the expectation is queued before the request goes out
   task automatic cpu(input logic w, input logic [29:0] ca, input logic [31:0] d, input logic c);
      exp_q.push_back({c, d});
      if (w)
         sb[ca] = d;
      @(posedge clk);
      req <= 1'b1;
      we <= w;
      addr <= ca;
      wdata <= d;
      lat = 0;
      do begin
         @(posedge clk);
         lat++;
      end while (rdy !== 1'b1 && lat < 300);
      req <= 1'b0;
   endtask
   // each ready pulse retires the oldest expectation
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         num_errors++;
         conclude();
      end else if (rdy === 1'b1 && exp_q.size() > 0) begin
         t = exp_q[0][31:0];
         if (exp_q.pop_front() >> 32)
            check("rdata", rdata, t);
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      reg_r(REG_CTRL, {20'h0, CTRL_RST});
      reg_r(REG_NC0, {15'h0, NC_RST});
      reg_r(4'h2, 32'h0);
      reg_w(REG_CTRL, 32'h0A03); // cache on, hidden refresh, two banks of 1M
      reg_r(REG_CTRL, 32'h0A03);
      // copy-back: set 0x100 gets three tags so one dirty way is evicted
      n0 = mem_inst.wr_cnt;
      cpu(1'b1, 30'h100, 32'h1111_0000, 1'b0);
      cpu(1'b0, 30'h100, sb[30'h100], 1'b1);
      cpu(1'b0, 30'h100, sb[30'h100], 1'b1);
      cpu(1'b1, 30'h100, 32'h2222_0000, 1'b0);
      check("hit write latency", 32'(lat), 32'd2);
      cpu(1'b1, 30'h500, 32'h5555_0000, 1'b0);
      cpu(1'b1, 30'h900, 32'h9999_0000, 1'b0);
      cpu(1'b0, 30'h500, sb[30'h500], 1'b1);
      repeat (8) @(posedge clk);
      check("writes before evict", 32'(mem_inst.wr_cnt - n0), 32'd3);
      cpu(1'b0, 30'h900, sb[30'h900], 1'b1);
      repeat (8) @(posedge clk);
      check("writes after evict", 32'(mem_inst.wr_cnt - n0), 32'd4);
      cpu(1'b0, 30'h100, sb[30'h100], 1'b1);
      // rom region goes out on the rom port until it is shadowed
      n0 = mem_inst.rom_cnt;
      cpu(1'b0, {SYS_ROM, 14'h10}, {2'h0, SYS_ROM, 14'h10}, 1'b1);
      reg_w(REG_CTRL, 32'h0A37); // system shadow on, 3 wait states
      cpu(1'b0, {SYS_ROM, 14'h10}, 32'h0, 1'b0);
      check("rom accesses", 32'(mem_inst.rom_cnt - n0), 32'd1);
      // non-cacheable block two: every read reaches the dram
      reg_w(REG_NC0, 32'h0001_0102);
      cpu(1'b1, 30'h8004, 32'hC0DE_0001, 1'b0);
      n0 = mem_inst.rd_cnt;
      cpu(1'b0, 30'h8004, sb[30'h8004], 1'b1);
      cpu(1'b0, 30'h8004, sb[30'h8004], 1'b1);
      check("uncached reads", 32'(mem_inst.rd_cnt - n0), 32'd2);
      // idle memory lets the deferred refreshes run
      n0 = mem_inst.ref_cnt;
      repeat (2 * REF_CYC + 100) @(posedge clk);
      check("refresh idle", 32'(mem_inst.ref_cnt - n0 >= 2), 32'd1);
      // random traffic over both banks, few tags per set so lines churn
      for (int i = 0; i < 600; i++) begin
         t = $random(seed);
         a = {9'h0, t[20], 7'h0, t[12:0]};
         if (t[31] || !sb.exists(a))
            cpu(1'b1, a, $random(seed), 1'b0);
         else
            cpu(1'b0, a, sb[a], 1'b1);
      end
      repeat (20) @(posedge clk);
      check("queue drained", 32'(exp_q.size()), 32'd0);
      conclude();
   end
endmodule
